/* src/sioda_regs.vh */
// Register offsets, field positions, codes and reset values of the safety I/O device assignment block
`ifndef SIODA_REGS_VH
`define SIODA_REGS_VH
`define SIODA_OFF_IN_SEL 4'h0
`define SIODA_OFF_OUT_SEL 4'h1
`define SIODA_OFF_MODE 4'h2
`define SIODA_OFF_STATUS 4'h3
`define SIODA_OFF_CLEAR 4'h4
`define SIODA_OFF_ENABLE 4'h5
`define SIODA_OFF_ALARM 4'h6
`define SIODA_OFF_APPLY 4'h7
`define SIODA_SEL_RESET 32'h00000000
`define SIODA_DEV_LSB 0
`define SIODA_DEV_MSB 7
`define SIODA_COMB_BIT 8
`define SIODA_AXIS_LSB 12
`define SIODA_AXIS_MSB 15
`define SIODA_IN_NONE 8'h00
`define SIODA_IN_TORQUE_OFF 8'h01
`define SIODA_IN_STOP_ONE 8'h02
`define SIODA_OUT_NONE 8'h00
`define SIODA_OUT_TORQUE_OFF 8'h01
`define SIODA_OUT_STOP_ONE 8'h02
`define SIODA_OUT_BRAKE 8'h0A
`define SIODA_MODE_INPUT_DEV 4'h0
`define SIODA_MODE_TEST 4'h2
`define SIODA_RESP_OKAY 2'h0
`define SIODA_RESP_SLVERR 2'h2
`define SIODA_ST_RANGE 0
`define SIODA_ST_COMBO 1
`define SIODA_ST_PIN_IN 2
`endif

/* src/sioda_top.v */
// Safety I/O device assignment: input fan-out, output combine, parameter checks, AXI4-Lite registers
// Notes on behaviour
// - Input device code 00 none, 01 torque-off command, 02 stop-one command.
// - Any other input device code raises the range alarm.
// - Input-device mode with no input device, or inconsistent input, raises combination alarm.
// - Input axis mask bit 0 axis A, bit 1 axis B, bit 2 axis C; bit 3 reserved.
// - Input axis mask zero applies the input device to every axis.
// - Several axis bits drive the command to each enabled axis together.
// - Nonzero mask on one-axis unit, or axis C on two-axis unit, raises range alarm.
// - Output code 00 none, 01 torque-off, 02 stop-one, 0A brake-control status.
// - Any other output device code raises the range alarm.
// - Inconsistent output selection raises the combination alarm.
// - Combine digit 0: output significant only when all axes meet the condition.
// - Combine digit 1: output significant when any axis meets the condition.
// - Combine digit honoured only on multi-axis units with output axis set to all.
// - Output axis 0 all, 1 axis A, 2 axis B, 3 axis C.
// - Mode 0 input-device control; mode 2 test operation disables the sub-function.
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "sioda_regs.vh"
module sioda_top #(
	parameter NUM_AXES = 3
) (
	input wire core_clk,
	input wire rst_n,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire first_safety_input_pin,
	input wire [2:0] torque_off_state,
	input wire [2:0] stop_one_state,
	input wire [2:0] brake_control_state,
	output reg [2:0] torque_off_command,
	output reg [2:0] stop_one_command,
	output reg first_safety_output_pin,
	output reg irq
);
	// Register map, one word each at byte address index*4:
	// 0x00 staged input select, 0x04 staged output select, 0x08 staged mode
	// 0x0C status (range event, combination event, pin change), read only
	// 0x10 status clear, write one to clear
	// 0x14 interrupt enable, same layout as status
	// 0x18 alarm flags and synced pin level, read only
	// 0x1C apply: bit 0 copies the staged words into use
	// Staged words read back as written; applied words are not visible

	// Applied settings and software-visible registers
	reg [31:0] safety_input_one_select_reg;
	reg [31:0] safety_output_one_select_reg;
	reg [3:0] safety_input_mode_reg;
	reg [31:0] shadow_in_reg;
	reg [31:0] shadow_out_reg;
	reg [3:0] shadow_mode_reg;
	reg safety_range_alarm_reg;
	reg safety_combination_alarm_reg;
	reg [2:0] status_reg;
	reg [2:0] enable_reg;
	reg [2:0] pin_sync_reg;
	reg pin_level_reg;
	reg apply_pend_reg;
	// Write channel holding
	reg aw_have_reg;
	reg w_have_reg;
	reg [3:0] aw_idx_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;

	// Field views of the applied and staged settings
	wire [7:0] input_device_field = safety_input_one_select_reg[`SIODA_DEV_MSB:`SIODA_DEV_LSB];
	wire [3:0] input_axis_mask = safety_input_one_select_reg[`SIODA_AXIS_MSB:`SIODA_AXIS_LSB];
	wire [7:0] output_device_field = safety_output_one_select_reg[`SIODA_DEV_MSB:`SIODA_DEV_LSB];
	wire all_axis_combine_select = safety_output_one_select_reg[`SIODA_COMB_BIT];
	wire [3:0] output_axis_select = safety_output_one_select_reg[`SIODA_AXIS_MSB:`SIODA_AXIS_LSB];
	wire [7:0] sh_in_dev = shadow_in_reg[`SIODA_DEV_MSB:`SIODA_DEV_LSB];
	wire [3:0] sh_in_axis = shadow_in_reg[`SIODA_AXIS_MSB:`SIODA_AXIS_LSB];
	wire [7:0] sh_out_dev = shadow_out_reg[`SIODA_DEV_MSB:`SIODA_DEV_LSB];
	wire [3:0] sh_out_axis = shadow_out_reg[`SIODA_AXIS_MSB:`SIODA_AXIS_LSB];
	wire multi_axis = (NUM_AXES > 1);

	// Individual findings of the parameter checks, kept apart so each reads on its own
	wire in_code_bad = (sh_in_dev != `SIODA_IN_NONE) && (sh_in_dev != `SIODA_IN_TORQUE_OFF) &&
		(sh_in_dev != `SIODA_IN_STOP_ONE);
	wire out_code_bad = (sh_out_dev != `SIODA_OUT_NONE) && (sh_out_dev != `SIODA_OUT_TORQUE_OFF) &&
		(sh_out_dev != `SIODA_OUT_STOP_ONE) && (sh_out_dev != `SIODA_OUT_BRAKE);
	// A one-axis unit takes no mask at all; a two-axis unit has no axis C
	wire mask_single_bad = (NUM_AXES == 1) && (sh_in_axis != 4'h0);
	wire mask_pair_bad = (NUM_AXES == 2) && sh_in_axis[2];
	wire mask_bad = mask_single_bad || mask_pair_bad;
	wire mode_bad = (shadow_mode_reg != `SIODA_MODE_INPUT_DEV) && (shadow_mode_reg != `SIODA_MODE_TEST);
	// Input-device control needs a device on the first safety input
	wire in_missing = (shadow_mode_reg == `SIODA_MODE_INPUT_DEV) && (sh_in_dev == `SIODA_IN_NONE);
	// Reserved mask bit counts as inconsistent input selection
	wire in_reserved = sh_in_axis[3];
	wire in_combo_bad = in_missing || in_reserved;
	// Output axis beyond the fitted axes cannot be sourced
	wire out_axis_high = (sh_out_axis > 4'h3);
	wire out_axis_unfitted = (sh_out_axis != 4'h0) && (sh_out_axis > NUM_AXES);
	wire out_combo_bad = out_axis_high || out_axis_unfitted;

	// Parameter checks on the staged configuration
	reg chk_range;
	reg chk_combo;
	always @* begin
		chk_range = in_code_bad || out_code_bad || mask_bad || mode_bad;
		chk_combo = in_combo_bad || out_combo_bad;
	end

	// Axis fan-out of the single input pin
	wire [2:0] axes_fitted = (NUM_AXES >= 3) ? 3'h7 : (NUM_AXES == 2) ? 3'h3 : 3'h1;
	wire [2:0] in_axes = (input_axis_mask[2:0] == 3'h0) ? axes_fitted : input_axis_mask[2:0];
	wire func_on = (safety_input_mode_reg == `SIODA_MODE_INPUT_DEV) &&
		!safety_range_alarm_reg && !safety_combination_alarm_reg;
	// Commands need the function live and the synced pin asserted
	wire cmd_armed = func_on && pin_level_reg;
	wire to_selected = (input_device_field == `SIODA_IN_TORQUE_OFF);
	wire so_selected = (input_device_field == `SIODA_IN_STOP_ONE);
	wire [2:0] to_axis_on;
	wire [2:0] so_axis_on;
	// One pin fans out to every selected axis in the same cycle
	localparam AXIS_SLOTS = 3; // Command ports carry at most three axes
	genvar ax;
	generate
		for (ax = 0; ax < AXIS_SLOTS; ax = ax + 1) begin : g_axis
			assign to_axis_on[ax] = cmd_armed && to_selected && in_axes[ax];
			assign so_axis_on[ax] = cmd_armed && so_selected && in_axes[ax];
		end
	endgenerate

	// Per-axis output condition and combine
	reg [2:0] cond;
	reg out_cond;
	always @* begin
		case (output_device_field)
			`SIODA_OUT_TORQUE_OFF: cond = torque_off_state;
			`SIODA_OUT_STOP_ONE: cond = stop_one_state;
			`SIODA_OUT_BRAKE: cond = brake_control_state;
			default: cond = 3'h0;
		endcase
		// Unfitted axes read as not met, so the AND spans only fitted axes
		cond = cond & axes_fitted;
		case (output_axis_select)
			4'h1: out_cond = cond[0];
			4'h2: out_cond = cond[1];
			4'h3: out_cond = cond[2];
			default: begin
				if (multi_axis && all_axis_combine_select)
					out_cond = |cond;
				else if (multi_axis)
					out_cond = (cond == axes_fitted);
				else
					out_cond = cond[0];
			end
		endcase
	end

	// Channel handshakes, one item moves when valid and ready meet
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire b_take = s_axi_bvalid && s_axi_bready;
	wire r_take = s_axi_rvalid && s_axi_rready;

	// Bus decode helpers
	wire wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
	wire rd_go = s_axi_arvalid && s_axi_arready;
	wire [3:0] ar_idx = s_axi_araddr[5:2];
	// Status and alarm words are read only, so writes to them are refused
	wire wr_mapped = (aw_idx_reg <= `SIODA_OFF_APPLY) && (aw_idx_reg != `SIODA_OFF_STATUS) &&
		(aw_idx_reg != `SIODA_OFF_ALARM);
	// Clear strobe acts on byte 0 only
	wire wr_clear = wr_go && (aw_idx_reg == `SIODA_OFF_CLEAR) && wstrb_reg[0];

	// Pin change event fires on the cycle the settled level is taken
	wire pin_settled = (pin_sync_reg[1] == pin_sync_reg[2]);
	wire ev_pin = pin_settled && (pin_level_reg != pin_sync_reg[2]);
	// Check events only count on the apply cycle
	wire ev_combo = chk_combo & apply_pend_reg;
	wire ev_range = chk_range & apply_pend_reg;
	wire [2:0] events = {ev_pin, ev_combo, ev_range};

	// Byte-lane merge under the write strobes
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] be;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1)
				merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	// Write channels: address and data taken in either order, response after both
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SIODA_RESP_OKAY;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_idx_reg <= 4'h0;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
		end else begin
			// Ready is a single pulse so a held valid is taken once
			s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
			if (aw_take) begin
				aw_have_reg <= 1'b1;
				aw_idx_reg <= (s_axi_awaddr[31:6] == 26'h0) ? s_axi_awaddr[5:2] : 4'hF;
			end
			if (w_take) begin
				w_have_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? `SIODA_RESP_OKAY : `SIODA_RESP_SLVERR;
			end else if (b_take)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Staged settings take effect only on apply, so checks and outputs never see half a setting
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			shadow_in_reg <= `SIODA_SEL_RESET;
			shadow_out_reg <= `SIODA_SEL_RESET;
			shadow_mode_reg <= `SIODA_MODE_INPUT_DEV;
			safety_input_one_select_reg <= `SIODA_SEL_RESET;
			safety_output_one_select_reg <= `SIODA_SEL_RESET;
			safety_input_mode_reg <= `SIODA_MODE_INPUT_DEV;
			enable_reg <= 3'h0;
			apply_pend_reg <= 1'b0;
			safety_range_alarm_reg <= 1'b0;
			safety_combination_alarm_reg <= 1'b0;
		end else begin
			apply_pend_reg <= 1'b0;
			// Mode, enable and apply use byte 0 only
			if (wr_go) begin
				case (aw_idx_reg)
					`SIODA_OFF_IN_SEL: shadow_in_reg <= merge(shadow_in_reg, wdata_reg, wstrb_reg);
					`SIODA_OFF_OUT_SEL: shadow_out_reg <= merge(shadow_out_reg, wdata_reg, wstrb_reg);
					`SIODA_OFF_MODE: if (wstrb_reg[0]) shadow_mode_reg <= wdata_reg[3:0];
					`SIODA_OFF_ENABLE: if (wstrb_reg[0]) enable_reg <= wdata_reg[2:0];
					`SIODA_OFF_APPLY: if (wstrb_reg[0] && wdata_reg[0]) apply_pend_reg <= 1'b1;
					default: ;
				endcase
			end
			if (apply_pend_reg) begin
				safety_input_one_select_reg <= shadow_in_reg;
				safety_output_one_select_reg <= shadow_out_reg;
				safety_input_mode_reg <= shadow_mode_reg;
				// Alarms only ever set; a clean apply cannot clear them
				if (chk_range)
					safety_range_alarm_reg <= 1'b1;
				if (chk_combo)
					safety_combination_alarm_reg <= 1'b1;
			end
		end
	end

	// Sticky event status; a new event beats a simultaneous clear
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			status_reg <= 3'h0;
		else if (wr_clear)
			status_reg <= (status_reg & ~wdata_reg[2:0]) | events;
		else
			status_reg <= status_reg | events;
	end

	// Words as software sees them on a read
	wire [31:0] mode_word = {28'h0, shadow_mode_reg};
	wire [31:0] status_word = {29'h0, status_reg};
	wire [31:0] enable_word = {29'h0, enable_reg};
	wire [31:0] alarm_word = {29'h0, pin_level_reg, safety_combination_alarm_reg, safety_range_alarm_reg};

	// Read decode; write-only and unmapped words read as zero
	reg [31:0] rd_word;
	reg rd_err;
	always @* begin
		rd_word = 32'h00000000;
		rd_err = 1'b0;
		if (s_axi_araddr[31:6] != 26'h0)
			rd_err = 1'b1;
		else begin
			case (ar_idx)
				`SIODA_OFF_IN_SEL: rd_word = shadow_in_reg;
				`SIODA_OFF_OUT_SEL: rd_word = shadow_out_reg;
				`SIODA_OFF_MODE: rd_word = mode_word;
				`SIODA_OFF_STATUS: rd_word = status_word;
				`SIODA_OFF_CLEAR: rd_word = 32'h00000000;
				`SIODA_OFF_ENABLE: rd_word = enable_word;
				`SIODA_OFF_ALARM: rd_word = alarm_word;
				`SIODA_OFF_APPLY: rd_word = 32'h00000000;
				default: rd_err = 1'b1;
			endcase
		end
	end

	// Read channel, one cycle after the address is taken
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `SIODA_RESP_OKAY;
		end else begin
			// A pending answer blocks the next address so reads never overlap
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_err ? `SIODA_RESP_SLVERR : `SIODA_RESP_OKAY;
			end else if (r_take)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Pin synchroniser; a level is accepted once stages two and three agree
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_sync_reg <= 3'h0;
			pin_level_reg <= 1'b0;
		end else begin
			pin_sync_reg <= {pin_sync_reg[1:0], first_safety_input_pin};
			// A level that still disagrees between stages two and three is held off
			if (pin_settled)
				pin_level_reg <= pin_sync_reg[2];
		end
	end

	// Next values of the registered outputs
	wire [2:0] torque_off_command_next = to_axis_on;
	wire [2:0] stop_one_command_next = so_axis_on;
	// Outputs drop whenever the function is off, so a bad setting never drives the pin
	wire first_safety_output_pin_next = func_on && out_cond;
	wire irq_next = |(status_reg & enable_reg);

	// Registered safety outputs and interrupt
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			torque_off_command <= 3'h0;
			stop_one_command <= 3'h0;
			first_safety_output_pin <= 1'b0;
			irq <= 1'b0;
		end else begin
			torque_off_command <= torque_off_command_next;
			stop_one_command <= stop_one_command_next;
			first_safety_output_pin <= first_safety_output_pin_next;
			irq <= irq_next;
		end
	end
endmodule // sioda_top
`default_nettype wire

/* bench/sioda_checker.sv */
// Port-level assertions of the safety I/O device assignment block
`timescale 1ns/100ps
`default_nettype none
module sioda_checker (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic first_safety_input_pin,
	input wire logic [2:0] torque_off_state,
	input wire logic [2:0] stop_one_state,
	input wire logic [2:0] brake_control_state,
	input wire logic [2:0] torque_off_command,
	input wire logic [2:0] stop_one_command,
	input wire logic first_safety_output_pin
);
	wire [8:0] cond = {torque_off_state, stop_one_state, brake_control_state};
	logic [5:0] pin_hist;
	// Recent pin levels; the synchroniser delay is not exact, so a span is kept
	always @(posedge core_clk) pin_hist <= {pin_hist[4:0], first_safety_input_pin};
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_cmd_excl: assert property ((torque_off_command & stop_one_command) == 3'h0) else $error("two commands");
	a_cmd_pin: assert property ($rose(|{torque_off_command, stop_one_command}) |-> |pin_hist[5:1])
		else $error("command without pin");
	a_out_cause: assert property ($rose(first_safety_output_pin) |-> $past(cond) != 9'h0)
		else $error("output without cause");
	a_out_idle: assert property ((cond == 9'h0) [*3] |-> !first_safety_output_pin) else $error("output idle");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
	a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready long");
	a_b_gap: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid twice");
	cover property (|torque_off_command);
	cover property (first_safety_output_pin);
	cover property (s_axi_bvalid && s_axi_bready);
endmodule // sioda_checker
`default_nettype wire

/* bench/sioda_partner.sv */
// External safety wiring driving the single input pin
`timescale 1ns/100ps
`default_nettype none
module sioda_partner (
	input wire logic core_clk,
	input wire logic demand,
	output logic first_safety_input_pin
);
	// Contact follows the demand a clock later, like a relay
	always @(posedge core_clk) first_safety_input_pin <= demand;
endmodule // sioda_partner
`default_nettype wire

/* bench/safety_io_device_assignment_bench.sv */
// Self-checking bench of the safety I/O device assignment block
`timescale 1ns/100ps
`default_nettype none
module safety_io_device_assignment_bench;
	logic core_clk = 1'h0, rst_n = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0, demand = 1'h0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rd_d;
	logic [2:0] to_s = 3'h0, so_s = 3'h0, bc_s = 3'h0;
	logic [1:0] resp;
	wire awready, wready, bvalid, arready, rvalid, pin_in, pin_out, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [2:0] to_c, so_c;
	int error_cnt = 0, compares = 0;
	initial forever #4 core_clk = ~core_clk;
	sioda_partner u_wire (.core_clk(core_clk), .demand(demand), .first_safety_input_pin(pin_in));
	sioda_top #(.NUM_AXES(3)) dut (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.first_safety_input_pin(pin_in), .torque_off_state(to_s), .stop_one_state(so_s),
		.brake_control_state(bc_s), .torque_off_command(to_c), .stop_one_command(so_c),
		.first_safety_output_pin(pin_out), .irq(irq));
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// Outputs are read right after the edge, before the design's updates land
	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [1:0] p;
		p = 2'h3;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		while (p != 2'h0) begin
			@(posedge core_clk);
			p = p & ~{awready, wready};
			{awvalid, wvalid} <= p;
		end
		do @(posedge core_clk); while (!bvalid);
		resp = bresp;
		bready <= 1'h0;
	endtask
	task rd(input logic [31:0] a);
		@(posedge core_clk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do @(posedge core_clk); while (!arready);
		arvalid <= 1'h0;
		do @(posedge core_clk); while (!rvalid);
		rd_d = rdata;
		resp = rresp;
		rready <= 1'h0;
	endtask
	task apply();
		wr(32'h1C, 32'h1);
		repeat (6) @(posedge core_clk);
	endtask
	task out_case(input logic [31:0] sel, input logic [8:0] st, input logic e);
		wr(32'h04, sel);
		apply();
		{to_s, so_s, bc_s} <= st;
		repeat (4) @(posedge core_clk);
		chk("out_pin", e, pin_out);
	endtask
	task t_reset();
		rd(32'h00);
		chk("in_sel", 32'h0, rd_d);
		rd(32'h04);
		chk("out_sel", 32'h0, rd_d);
	endtask
	// Mask 5 fans the torque-off command to axes A and C only
	task t_in_mask();
		wr(32'h00, 32'h5001);
		apply();
		rd(32'h18);
		chk("alarm", 2'h0, rd_d[1:0]);
		demand <= 1'h1;
		repeat (10) @(posedge core_clk);
		chk("to_cmd", 3'h5, to_c);
		chk("so_cmd", 3'h0, so_c);
		demand <= 1'h0;
		repeat (10) @(posedge core_clk);
		chk("to_cmd", 3'h0, to_c);
	endtask
	// Zero mask reaches every axis; test mode silences the commands
	task t_in_all();
		wr(32'h00, 32'h0002);
		apply();
		demand <= 1'h1;
		repeat (10) @(posedge core_clk);
		chk("so_cmd", 3'h7, so_c);
		wr(32'h08, 32'h2);
		apply();
		chk("so_cmd", 3'h0, so_c);
		wr(32'h08, 32'h0);
		apply();
		chk("so_cmd", 3'h7, so_c);
	endtask
	task t_out();
		out_case(32'h0001, 9'h0C0, 1'h0);
		out_case(32'h0001, 9'h1C0, 1'h1);
		out_case(32'h0101, 9'h080, 1'h1);
		out_case(32'h2002, 9'h010, 1'h1);
		out_case(32'h2002, 9'h028, 1'h0);
		out_case(32'h110A, 9'h006, 1'h0);
		out_case(32'h300A, 9'h004, 1'h1);
		out_case(32'h0000, 9'h1FF, 1'h0);
	endtask
	// Bad output code latches the alarm; clearing drops only the event
	task t_alarm();
		wr(32'h14, 32'h1);
		out_case(32'h0003, 9'h1FF, 1'h0);
		rd(32'h18);
		chk("alarm", 1'h1, rd_d[0]);
		chk("irq", 1'h1, irq);
		chk("so_cmd", 3'h0, so_c);
		wr(32'h10, 32'h1);
		repeat (3) @(posedge core_clk);
		chk("irq", 1'h0, irq);
		rd(32'h18);
		chk("alarm", 1'h1, rd_d[0]);
		wr(32'h0C, 32'h0);
		chk("bresp", 2'h2, resp);
		rd(32'h20);
		chk("rresp", 2'h2, resp);
	endtask
	task reboot();
		@(posedge core_clk);
		rst_n <= 1'h0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'h1;
	endtask
	// Alarms stick until reset, so every case starts from a fresh reset
	task t_combo();
		reboot();
		apply();
		rd(32'h18);
		chk("combo", 2'h2, rd_d[1:0]);
		reboot();
		wr(32'h00, 32'h0004);
		apply();
		rd(32'h18);
		chk("range", 2'h1, rd_d[1:0]);
		reboot();
		wr(32'h00, 32'h0001);
		wr(32'h04, 32'h4001);
		apply();
		rd(32'h18);
		chk("combo", 2'h2, rd_d[1:0]);
		chk("to_cmd", 3'h0, to_c);
	endtask
	task wrap_up();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'h1;
		t_reset();
		t_in_mask();
		t_in_all();
		t_out();
		t_alarm();
		t_combo();
		wrap_up();
	end
	// Watchdog well beyond the expected run
	initial begin
		#100000;
		error_cnt++;
		wrap_up();
	end
endmodule // safety_io_device_assignment_bench
bind sioda_top sioda_checker u_chk (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awready(s_axi_awready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .first_safety_input_pin(first_safety_input_pin),
	.torque_off_state(torque_off_state), .stop_one_state(stop_one_state),
	.brake_control_state(brake_control_state), .torque_off_command(torque_off_command),
	.stop_one_command(stop_one_command), .first_safety_output_pin(first_safety_output_pin));
`default_nettype wire
